// >>> hdl/embp_fifo.sv
// Empty: the request FIFO module is kept in the same file as the top level

// >>> hdl/embp_pkg.sv
// Package: constants and types for the external memory bus port
package embp_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned GLOBAL_AW = 15;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam int unsigned FIFO_DEPTH = 4;
   // Bus space codes on the request port
   typedef enum logic [1:0]
   {
      EMBP_SP_PROG = 2'b00,
      EMBP_SP_DATA = 2'b01,
      EMBP_SP_IO = 2'b10,
      EMBP_SP_GLOBAL = 2'b11
   } embp_space_t;
endpackage : embp_pkg

// >>> hdl/embp_port.sv
// File: external memory bus port, top level and its request FIFO
`timescale 1ns/10ps
//==========================================================
// Overview of operation
// [RULE1] Sixteen-bit two-way data bus, bit 15 most significant, shared by all spaces.
// [RULE2] Data bus released unless driving write data, and while reset input is low.
// [RULE3] Sixteen-bit address bus selects program, data or I/O locations.
// [RULE4] Output-disable low floats address, data and every bus control output.
// [RULE5] Program select high except during off-chip program space cycles.
// [RULE6] Data select high except during off-chip data space cycles.
// [RULE7] I/O select high except during I/O port cycles.
// [RULE8] Ready sampled each cycle; low means wait one cycle and sample again.
// [RULE9] External device raises ready only when done; tie high when unused.
// [RULE10] Read/write line high by default, low only during writes.
// [RULE11] Bus-cycle strobe high, low only during an active external cycle.
// [RULE12] Read select low during every external read, fit for output enables.
// [RULE13] Internal I/O register accesses still show I/O select, direction, data.
// [RULE14] Write strobe falls as data bus is driven; data valid at its rise.
// [RULE15] Global bus request low during global data space accesses.
// [RULE16] At most one space select active per cycle, with the strobe; internal I/O accesses drop I/O select without it.
module embp_port
   import embp_pkg::*;
#(
   parameter int unsigned DEPTH = embp_pkg::FIFO_DEPTH
)
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic reset_in_n,
   input wire logic output_disable_n,
   // Core request port, buffered through the FIFO
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire embp_pkg::embp_space_t req_space,
   input wire logic req_internal,
   input wire logic [embp_pkg::ADDR_W-1:0] req_addr,
   input wire logic [embp_pkg::DATA_W-1:0] req_wdata,
   // Read data back to the core
   output logic rsp_valid,
   output logic [embp_pkg::DATA_W-1:0] rsp_rdata,
   // Pins
   input wire logic ready,
   output logic [embp_pkg::ADDR_W-1:0] addr_o,
   output logic addr_oe,
   input wire logic [embp_pkg::DATA_W-1:0] data_i,
   output logic [embp_pkg::DATA_W-1:0] data_o,
   output logic data_oe,
   output logic program_space_select_n,
   output logic data_space_select_n,
   output logic io_space_select_n,
   output logic bus_cycle_strobe_n,
   output logic read_select_n,
   output logic read_write,
   output logic write_strobe_n,
   output logic global_bus_request_n,
   output logic ctrl_oe
);
   import embp_pkg::*;

   localparam int unsigned RW = 2 + 1 + 1 + ADDR_W + DATA_W;

   typedef enum logic [1:0] {EMBP_IDLE, EMBP_ACCESS, EMBP_DONE} embp_state_t;

   logic [RW-1:0] fifo_in, fifo_out;
   logic fifo_valid, fifo_pop;
   embp_space_t f_space;
   logic [1:0] f_space_bits;
   logic f_write, f_internal;
   logic [ADDR_W-1:0] f_addr;
   logic [DATA_W-1:0] f_wdata;

   assign fifo_in = {req_space, req_write, req_internal, req_addr, req_wdata};
   assign {f_space_bits, f_write, f_internal, f_addr, f_wdata} = fifo_out;
   assign f_space = embp_space_t'(f_space_bits);

   embp_fifo #(.WIDTH(RW), .DEPTH(DEPTH)) u_fifo
   (
      .ref_clk(ref_clk),
      .srst(srst),
      .in_valid(req_valid),
      .in_ready(req_ready),
      .in_data(fifo_in),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out)
   );

   //==========================================================
   // Bus cycle sequencer
   embp_state_t state_ff, nxt_state;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic [DATA_W-1:0] dout_ff, nxt_dout;
   logic dout_en_ff, nxt_dout_en;
   logic ps_n_ff, nxt_ps_n, ds_n_ff, nxt_ds_n, is_n_ff, nxt_is_n;
   logic bus_cycle_strobe_n_n_ff, nxt_bus_cycle_strobe_n_n, rd_n_ff, nxt_rd_n, rw_ff, nxt_rw;
   logic we_n_ff, nxt_we_n, br_n_ff, nxt_br_n;
   logic rsp_v_ff, nxt_rsp_v;
   logic [DATA_W-1:0] rsp_d_ff, nxt_rsp_d;
   logic ext_ff, nxt_ext;
   logic oe_ff, drive_ff;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_addr = addr_ff;
      nxt_dout = dout_ff;
      nxt_dout_en = dout_en_ff;
      nxt_ps_n = ps_n_ff;
      nxt_ds_n = ds_n_ff;
      nxt_is_n = is_n_ff;
      nxt_bus_cycle_strobe_n_n = bus_cycle_strobe_n_n_ff;
      nxt_rd_n = rd_n_ff;
      nxt_rw = rw_ff;
      nxt_we_n = we_n_ff;
      nxt_br_n = br_n_ff;
      nxt_rsp_v = 1'b0;
      nxt_rsp_d = rsp_d_ff;
      nxt_ext = ext_ff;
      fifo_pop = 1'b0;
      case (state_ff)
         EMBP_IDLE:
         begin
            if (fifo_valid)
            begin
               fifo_pop = 1'b1;
               nxt_state = EMBP_ACCESS;
               nxt_addr = f_addr; // [RULE3]
               // Internal I/O register accesses skip strobes but stay visible
               nxt_ext = !f_internal;
               nxt_bus_cycle_strobe_n_n = f_internal; // [RULE11]
               // Only off-chip cycles may drop the program, data and global selects
               nxt_ps_n = !(nxt_ext && f_space == EMBP_SP_PROG); // [RULE5] [RULE16]
               nxt_ds_n = !(nxt_ext && (f_space == EMBP_SP_DATA
                  || f_space == EMBP_SP_GLOBAL)); // [RULE6]
               nxt_is_n = !(f_space == EMBP_SP_IO); // [RULE7] [RULE13]
               nxt_br_n = !(nxt_ext && f_space == EMBP_SP_GLOBAL); // [RULE15]
               nxt_rw = !f_write; // [RULE10] [RULE13]
               nxt_rd_n = f_write || f_internal; // [RULE12]
               nxt_we_n = !(f_write && !f_internal); // [RULE14]
               nxt_dout = f_wdata;
               nxt_dout_en = f_write; // [RULE1] [RULE13] [RULE14]
            end
         end
         EMBP_ACCESS:
         begin
            // Internal accesses take one cycle and ignore ready
            if (ready || !ext_ff) // [RULE8] [RULE9]
            begin
               nxt_state = EMBP_DONE;
               nxt_rsp_v = rw_ff;
               nxt_rsp_d = data_i;
               nxt_bus_cycle_strobe_n_n = 1'b1;
               nxt_ps_n = 1'b1;
               nxt_ds_n = 1'b1;
               nxt_is_n = 1'b1;
               nxt_br_n = 1'b1;
               nxt_rd_n = 1'b1;
               nxt_we_n = 1'b1; // [RULE14]
            end
         end
         EMBP_DONE:
         begin
            // Turnaround cycle: data held past the write strobe rise
            nxt_state = EMBP_IDLE;
            nxt_dout_en = 1'b0; // [RULE2]
            nxt_rw = 1'b1; // [RULE10]
         end
         default:
         begin
            nxt_state = EMBP_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state_ff <= EMBP_IDLE;
         addr_ff <= ADDR_RST;
         dout_ff <= DATA_RST;
         dout_en_ff <= 1'b0;
         ps_n_ff <= 1'b1;
         ds_n_ff <= 1'b1;
         is_n_ff <= 1'b1;
         bus_cycle_strobe_n_n_ff <= 1'b1;
         rd_n_ff <= 1'b1;
         rw_ff <= 1'b1;
         we_n_ff <= 1'b1;
         br_n_ff <= 1'b1;
         rsp_v_ff <= 1'b0;
         rsp_d_ff <= DATA_RST;
         ext_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         addr_ff <= nxt_addr;
         dout_ff <= nxt_dout;
         dout_en_ff <= nxt_dout_en;
         ps_n_ff <= nxt_ps_n;
         ds_n_ff <= nxt_ds_n;
         is_n_ff <= nxt_is_n;
         bus_cycle_strobe_n_n_ff <= nxt_bus_cycle_strobe_n_n;
         rd_n_ff <= nxt_rd_n;
         rw_ff <= nxt_rw;
         we_n_ff <= nxt_we_n;
         br_n_ff <= nxt_br_n;
         rsp_v_ff <= nxt_rsp_v;
         rsp_d_ff <= nxt_rsp_d;
         ext_ff <= nxt_ext;
      end
   end

   //==========================================================
   // Pin enables, registered so every enable comes from a flip-flop
   logic nxt_oe, nxt_drive;

   always_comb
   begin
      nxt_oe = output_disable_n; // [RULE4]
      nxt_drive = output_disable_n && reset_in_n && nxt_dout_en; // [RULE2] [RULE4]
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         oe_ff <= 1'b0;
         drive_ff <= 1'b0;
      end
      else
      begin
         oe_ff <= nxt_oe;
         drive_ff <= nxt_drive;
      end
   end

   assign addr_o = addr_ff;
   assign addr_oe = oe_ff;
   assign data_o = dout_ff;
   assign data_oe = drive_ff;
   assign program_space_select_n = ps_n_ff;
   assign data_space_select_n = ds_n_ff;
   assign io_space_select_n = is_n_ff;
   assign bus_cycle_strobe_n = bus_cycle_strobe_n_n_ff;
   assign read_select_n = rd_n_ff;
   assign read_write = rw_ff;
   assign write_strobe_n = we_n_ff;
   assign global_bus_request_n = br_n_ff;
   assign ctrl_oe = oe_ff;
   assign rsp_valid = rsp_v_ff;
   assign rsp_rdata = rsp_d_ff;
endmodule : embp_port

//==========================================================
// Request FIFO: flip-flop storage, valid/ready on both sides
module embp_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 4
)
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] nxt_mem [DEPTH];
   logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [PW:0] cnt_ff, nxt_cnt;
   // Not-full flag kept in a flip-flop so req_ready leaves the block registered
   logic ready_ff, nxt_ready;
   logic push, pop;

   always_comb
   begin
      push = in_valid && ready_ff;
      pop = out_ready && (cnt_ff != '0);
      nxt_wr = wr_ff;
      nxt_rd = rd_ff;
      nxt_cnt = cnt_ff;
      if (push)
      begin
         nxt_wr = (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + PW'(1);
      end
      if (pop)
      begin
         nxt_rd = (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + PW'(1);
      end
      if (push && !pop)
      begin
         nxt_cnt = cnt_ff + (PW+1)'(1);
      end
      else if (pop && !push)
      begin
         nxt_cnt = cnt_ff - (PW+1)'(1);
      end
      nxt_ready = (nxt_cnt != (PW+1)'(DEPTH));
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
         ready_ff <= 1'b1;
      end
      else
      begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
         ready_ff <= nxt_ready;
      end
   end

   // Storage has no reset; entries are only read once written
   always_comb
   begin
      nxt_mem = mem_ff;
      if (push)
      begin
         nxt_mem[wr_ff] = in_data;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      mem_ff <= nxt_mem;
   end

   assign in_ready = ready_ff;
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ff];
endmodule : embp_fifo

// >>> verif/embp_mem_model.sv
// Partner model: external memory with random wait states
`timescale 1ns/10ps
module embp_mem_model (
   input wire logic ref_clk,
   input wire logic slow,
   input wire logic [15:0] addr_o,
   input wire logic [15:0] data_o,
   input wire logic data_oe,
   input wire logic bus_cycle_strobe_n,
   input wire logic read_select_n,
   input wire logic write_strobe_n,
   output logic ready,
   output logic [15:0] data_i
);
   logic [15:0] mem [16];
   logic [15:0] last_ff = 16'h0000;
   logic [1:0] wait_ff = 2'h0;
   logic wsn_q = 1'b1;
   initial for (int i = 0; i < 16; i++) mem[i] = {4{i[3:0]}};
   // Ready stays low until the wait runs out
   assign ready = (wait_ff == 2'h0);
   // Released bus shows the inverse of its last value, so stale data cannot pass
   assign data_i = !read_select_n ? mem[addr_o[3:0]] : ~last_ff;
   always @(posedge ref_clk)
   begin
      last_ff <= data_i;
      wsn_q <= write_strobe_n;
      if (bus_cycle_strobe_n)
         wait_ff <= slow ? 2'($urandom_range(3, 0)) : 2'h0;
      else if (wait_ff != 2'h0)
         wait_ff <= wait_ff - 2'h1;
      if (!wsn_q && write_strobe_n && data_oe)
         mem[addr_o[3:0]] <= data_o;
   end
endmodule : embp_mem_model

// >>> verif/embp_port_bench.sv
// Testbench: self-checking bench for the external memory bus port
`timescale 1ns/10ps
module embp_port_bench;
   import embp_pkg::*;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic reset_in_n = 1'b1;
   logic output_disable_n = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic req_internal = 1'b0;
   logic slow = 1'b0;
   embp_space_t req_space = EMBP_SP_PROG;
   logic [15:0] req_addr = 16'h0000;
   logic [15:0] req_wdata = 16'h0000;
   logic req_ready, rsp_valid, ready, addr_oe, data_oe, ctrl_oe, read_write;
   logic program_space_select_n, data_space_select_n, io_space_select_n;
   logic bus_cycle_strobe_n, read_select_n, write_strobe_n, global_bus_request_n;
   logic [15:0] rsp_rdata, addr_o, data_i, data_o;
   logic [15:0] ref_mem [16];
   logic [15:0] exp_q [$];
   int n_fail = 0;
   int num_checks = 0;
   int full_seen = 0;
   embp_port uut (.*);
   embp_mem_model u_mem (.*);
   initial forever #10 ref_clk = ~ref_clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Requests stay valid back to back; the reference mirrors memory in issue order
   task automatic send(input logic w, input embp_space_t sp, input logic intl,
      input logic [15:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      req_valid = 1'b1;
      req_write = w;
      req_space = sp;
      req_internal = intl;
      req_addr = a;
      req_wdata = d;
      while (req_ready !== 1'b1)
      begin
         full_seen++;
         @(negedge ref_clk);
      end
      if (!intl && !w)
         exp_q.push_back(ref_mem[a[3:0]]);
      else if (!intl)
         ref_mem[a[3:0]] = d;
   endtask : send
   task automatic end_sim();
      if (n_fail == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   always @(negedge ref_clk)
      if (rsp_valid === 1'b1)
         check(rsp_rdata, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
   initial
   begin
      #100000;
      n_fail++;
      end_sim();
   end
   initial
   begin
      logic w;
      logic seen_oe;
      void'($urandom(53));
      for (int i = 0; i < 16; i++) ref_mem[i] = {4{i[3:0]}};
      repeat (16) @(negedge ref_clk);
      srst = 1'b0;
      reset_in_n = 1'b0;
      // A write while the device reset is held must leave the data bus released
      send(1'b1, EMBP_SP_IO, 1'b1, 16'h0005, 16'h5a5a);
      seen_oe = 1'b0;
      repeat (8)
      begin
         @(negedge ref_clk);
         req_valid = 1'b0;
         seen_oe = seen_oe | data_oe;
      end
      check(16'(seen_oe), 16'h0000);
      reset_in_n = 1'b1;
      output_disable_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      check({13'h0000, addr_oe, ctrl_oe, data_oe}, 16'h0000);
      output_disable_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      check({14'h0000, addr_oe, ctrl_oe}, 16'h0003);
      for (int s = 0; s < 4; s++)
      begin
         send(1'b1, embp_space_t'(s), 1'b0, 16'(s), 16'hc3c3 ^ 16'(s));
         send(1'b0, embp_space_t'(s), 1'b0, 16'(s), 16'h0000);
      end
      // Internal write must not reach external memory
      send(1'b1, EMBP_SP_IO, 1'b1, 16'h0005, 16'hffff);
      send(1'b0, EMBP_SP_IO, 1'b0, 16'h0005, 16'h0000);
      slow = 1'b1;
      repeat (60)
      begin
         w = 1'($urandom);
         send(w, embp_space_t'($urandom_range(3, 0)), 1'b0, 16'($urandom), 16'($urandom));
      end
      @(negedge ref_clk);
      req_valid = 1'b0;
      for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(negedge ref_clk);
      repeat (8) @(negedge ref_clk);
      check(16'(exp_q.size()), 16'h0000);
      check(16'(full_seen > 0), 16'h0001);
      end_sim();
   end
endmodule : embp_port_bench

// >>> verif/embp_port_chk.sv
// Checker: pin-level assertions for the external memory bus port
`timescale 1ns/10ps
module embp_port_chk (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic reset_in_n,
   input wire logic output_disable_n,
   input wire logic ready,
   input wire logic rsp_valid,
   input wire logic addr_oe,
   input wire logic data_oe,
   input wire logic ctrl_oe,
   input wire logic program_space_select_n,
   input wire logic data_space_select_n,
   input wire logic io_space_select_n,
   input wire logic bus_cycle_strobe_n,
   input wire logic read_select_n,
   input wire logic read_write,
   input wire logic write_strobe_n,
   input wire logic global_bus_request_n
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // ====================
   // Pin relations
   chk_data_float: assert property (!reset_in_n |=> !data_oe)
      else $error("data driven in device reset");
   chk_off_float: assert property (!output_disable_n |=> !(addr_oe | ctrl_oe | data_oe))
      else $error("pins driven while disabled");
   chk_one_select: assert property (
      !bus_cycle_strobe_n |-> $countones({!program_space_select_n,
      !data_space_select_n, !io_space_select_n}) == 1)
      else $error("space selects not exactly one");
   chk_prog_ext: assert property (!program_space_select_n |-> !bus_cycle_strobe_n)
      else $error("program select outside cycle");
   chk_data_ext: assert property (!data_space_select_n |-> !bus_cycle_strobe_n)
      else $error("data select outside cycle");
   chk_io_internal: assert property (
      !io_space_select_n && bus_cycle_strobe_n |-> read_select_n && write_strobe_n)
      else $error("strobe on internal access");
   chk_read_sel: assert property (!read_select_n |-> read_write && !bus_cycle_strobe_n)
      else $error("read select without read cycle");
   chk_write_dir: assert property (
      !write_strobe_n && $past(reset_in_n) && $past(output_disable_n) |-> !read_write && data_oe)
      else $error("write strobe without driven data");
   chk_ready_wait: assert property (!bus_cycle_strobe_n && !ready |=> !bus_cycle_strobe_n)
      else $error("cycle ended without ready");
   chk_ready_end: assert property (!bus_cycle_strobe_n && ready |=> bus_cycle_strobe_n)
      else $error("cycle held past ready");
   chk_global_req: assert property (!global_bus_request_n |-> !data_space_select_n)
      else $error("bus request without data select");
   chk_rsp_cause: assert property (rsp_valid |-> !$past(read_select_n) && $past(ready))
      else $error("response without completed read");
   cover property (!bus_cycle_strobe_n && !ready);
   cover property (!global_bus_request_n);
   cover property (!io_space_select_n && bus_cycle_strobe_n);
endmodule : embp_port_chk

bind embp_port embp_port_chk u_chk (.*);
